// >>> design/electrode_status_bank.v
// Electrode range flags, lead-off status and device health status register bank.
`default_nettype none
`include "electrode_status_defines.vh"

module electrode_status_bank #(
  parameter ADDR_WIDTH = 8,
  parameter DATA_WIDTH = 24,
  parameter ELECTRODES = 5
) (
  input wire mclk,
  input wire sys_rst,
  input wire [ADDR_WIDTH-1:0] reg_addr,
  input wire [DATA_WIDTH-1:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [DATA_WIDTH-1:0] reg_rdata,
  input wire [ELECTRODES-1:0] overrange_cmp,
  input wire [ELECTRODES-1:0] underrange_cmp,
  input wire [ELECTRODES-1:0] ac_lead_off_cmp,
  input wire pll_lock_raw,
  input wire core_fault,
  input wire config_loaded,
  input wire frame_transfer,
  output reg power_enable,
  output reg ac_lead_off_enable,
  output reg dc_lead_off_enable,
  output reg irq
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  localparam SYNC_WIDTH = 3 * ELECTRODES + 1;

  wire [SYNC_WIDTH-1:0] sync_bus;
  wire [ELECTRODES-1:0] over_sync;
  wire [ELECTRODES-1:0] under_sync;
  wire [ELECTRODES-1:0] ac_sync;
  wire pll_locked;

  // Comparators are analog and asynchronous, so every level is resynchronised
  // before it is captured; a read then never sees a half-settled flag.
  electrode_sync #(
    .WIDTH(SYNC_WIDTH)
  ) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in({pll_lock_raw, ac_lead_off_cmp, underrange_cmp, overrange_cmp}),
    .sync_out(sync_bus)
  );

  // Split the synchronised bus back into its groups.
  assign over_sync = sync_bus[ELECTRODES-1:0];
  assign under_sync = sync_bus[2*ELECTRODES-1:ELECTRODES];
  assign ac_sync = sync_bus[3*ELECTRODES-1:2*ELECTRODES];
  assign pll_locked = sync_bus[SYNC_WIDTH-1];

  // ****************************************************************
  // Register bus decode
  // ****************************************************************
  wire wr_power;
  wire wr_mask;
  wire wr_lead_off_status_ctrl;
  wire rd_health;
  wire rd_event;

  // A read and a write never share a cycle, so the two strobe groups are
  // decoded apart and need no priority between them.
  // Write and read strobes qualified by address.
  assign wr_power = reg_write && (reg_addr == `POWER_CONTROL_ADDR);
  assign wr_mask = reg_write && (reg_addr == `EVENT_MASK_ADDR);
  assign wr_lead_off_status_ctrl = reg_write && (reg_addr == `LEAD_OFF_CONTROL_ADDR);
  assign rd_health = reg_read && (reg_addr == `DEVICE_HEALTH_STATUS_ADDR);
  assign rd_event = reg_read && (reg_addr == `EVENT_STATUS_ADDR);

  // ****************************************************************
  // Control registers
  // ****************************************************************
  reg [`EVENT_COUNT-1:0] event_mask;
  wire power_drop;

  // Software clearing the power enable bit is the second way to clear lock-lost.
  // Only a real one-to-zero change counts, so rewriting an idle enable with
  // zero leaves every flag alone.
  assign power_drop = wr_power && power_enable && !reg_wdata[`POWER_ENABLE_BIT];

  // Control bits written by software; all start disabled.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      power_enable <= 1'b0;
      ac_lead_off_enable <= 1'b0;
      dc_lead_off_enable <= 1'b0;
      event_mask <= {`EVENT_COUNT{1'b0}};
    end else begin
      if (wr_power) begin
        power_enable <= reg_wdata[`POWER_ENABLE_BIT];
      end
      if (wr_lead_off_status_ctrl) begin
        ac_lead_off_enable <= reg_wdata[`AC_ENABLE_BIT];
        dc_lead_off_enable <= reg_wdata[`DC_ENABLE_BIT];
      end
      if (wr_mask) begin
        event_mask <= reg_wdata[`EVENT_COUNT-1:0];
      end
    end
  end

  // ****************************************************************
  // DC lead-off flags
  // ****************************************************************
  reg [ELECTRODES-1:0] over_flag;
  reg [ELECTRODES-1:0] under_flag;

  // The flags are live levels, not sticky: the host sees the comparator state
  // of three cycles ago, which is the price of the synchroniser.
  // Flags follow the comparators live: one above threshold, zero otherwise.
  // Cleared by reset, so the register reads all zero right after it.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      over_flag <= {ELECTRODES{1'b0}};
      under_flag <= {ELECTRODES{1'b0}};
    end else begin
      over_flag <= over_sync;
      under_flag <= under_sync;
    end
  end

  // ****************************************************************
  // Lead-off status accumulation
  // ****************************************************************
  reg [ELECTRODES-1:0] lead_status;
  reg [ELECTRODES-1:0] lead_source;

  // Limitation: the field layout assumes five electrodes; another count needs
  // new field positions in the read word as well.
  // Pick the source: ac wins when both detectors run; the common electrode has
  // only dc detection, so it always takes the dc result.
  always @* begin
    lead_source = {ELECTRODES{1'b0}};
    if (ac_lead_off_enable) begin
      lead_source = ac_sync;
      lead_source[ELECTRODES-1] = dc_lead_off_enable &&
        (over_sync[ELECTRODES-1] || under_sync[ELECTRODES-1]);
    end else if (dc_lead_off_enable) begin
      lead_source = over_sync | under_sync;
    end
  end

  // Accumulate until the frame is handed to the output buffer; a flag raised
  // in the transfer cycle itself survives into the next frame.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lead_status <= {ELECTRODES{1'b0}};
    end else if (frame_transfer) begin
      lead_status <= lead_source;
    end else begin
      lead_status <= lead_status | lead_source;
    end
  end

  // ****************************************************************
  // Device health status
  // ****************************************************************
  reg internal_error;
  reg config_busy;
  reg lock_lost;
  reg lock_armed;
  reg pll_locked_q;
  wire lock_fall;

  // The edge is taken from the synchronised level and its delayed copy, so a
  // lock input that chatters near the clock edge cannot fake a loss.
  // Lock is only watched once the PLL is enabled and has locked at least once.
  assign lock_fall = lock_armed && pll_locked_q && !pll_locked;

  // Internal error is sticky until the health word is read; a new fault in
  // the read cycle wins over the clear.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      internal_error <= 1'b0;
    end else if (core_fault) begin
      internal_error <= 1'b1;
    end else if (rd_health) begin
      internal_error <= 1'b0;
    end
  end

  // Busy from reset until the configuration has been loaded.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      config_busy <= `CONFIG_BUSY_RESET;
    end else if (config_loaded) begin
      config_busy <= 1'b0;
    end
  end

  // Arming tracks enable plus first lock; dropping power disarms.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_armed <= 1'b0;
      pll_locked_q <= 1'b0;
    end else begin
      pll_locked_q <= pll_locked;
      if (!power_enable || power_drop) begin
        lock_armed <= 1'b0;
      end else if (pll_locked) begin
        lock_armed <= 1'b1;
      end
    end
  end

  // Lock-lost is sticky; a loss in the same cycle as a clear is kept.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_lost <= 1'b0;
    end else if (lock_fall) begin
      lock_lost <= 1'b1;
    end else if (rd_health || power_drop) begin
      lock_lost <= 1'b0;
    end
  end

  // ****************************************************************
  // Event status and interrupt
  // ****************************************************************
  reg [`EVENT_COUNT-1:0] event_status;
  reg [`EVENT_COUNT-1:0] event_set;
  reg [ELECTRODES-1:0] dc_prev;

  // Remember the previous dc flags to detect a new out-of-range condition.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dc_prev <= {ELECTRODES{1'b0}};
    end else begin
      dc_prev <= over_flag | under_flag;
    end
  end

  // Events that may raise the interrupt.
  always @* begin
    event_set = {`EVENT_COUNT{1'b0}};
    event_set[`EVENT_LOCK_LOST] = lock_fall;
    event_set[`EVENT_INTERNAL_ERROR] = core_fault;
    event_set[`EVENT_DC_FLAG] = |((over_flag | under_flag) & ~dc_prev);
    event_set[`EVENT_CONFIG_READY] = config_loaded && config_busy;
  end

  // Sticky event bits, cleared by a read; a set in the read cycle wins.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      event_status <= {`EVENT_COUNT{1'b0}};
    end else if (rd_event) begin
      event_status <= event_set;
    end else begin
      event_status <= event_status | event_set;
    end
  end

  // Registering the output keeps decode glitches off the interrupt pin, at the
  // cost of one cycle of latency.
  // The interrupt is registered, so it trails the status bit by one cycle.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(event_status & event_mask);
    end
  end

  // ****************************************************************
  // Read data path
  // ****************************************************************
  reg [DATA_WIDTH-1:0] next_rdata;

  // Reads have no side effect here; the clear-on-read flags are cleared by
  // their own address decode above, from the same strobe.
  // Build the read word; unmapped addresses and reserved bits read zero.
  // The dc flag word is reachable only here, never in a streamed frame.
  always @* begin
    next_rdata = `STATUS_RESET;
    case (reg_addr)
      `POWER_CONTROL_ADDR: begin
        next_rdata[`POWER_ENABLE_BIT] = power_enable;
      end
      `LEAD_OFF_STATUS_ADDR: begin
        next_rdata[`LEAD_STATUS_MSB:`LEAD_STATUS_LSB] = lead_status[ELECTRODES-2:0];
        next_rdata[`LEAD_STATUS_COMMON_BIT] = lead_status[ELECTRODES-1];
      end
      `DC_LEAD_OFF_FLAGS_ADDR: begin
        next_rdata[`OVERRANGE_MSB:`OVERRANGE_LSB] = over_flag[ELECTRODES-2:0];
        next_rdata[`OVERRANGE_COMMON_BIT] = over_flag[ELECTRODES-1];
        next_rdata[`UNDERRANGE_MSB:`UNDERRANGE_LSB] = under_flag[ELECTRODES-2:0];
        next_rdata[`UNDERRANGE_COMMON_BIT] = under_flag[ELECTRODES-1];
      end
      `DEVICE_HEALTH_STATUS_ADDR: begin
        // Bits above the defined fields stay at zero.
        next_rdata[`INTERNAL_ERROR_BIT] = internal_error;
        next_rdata[`CONFIG_BUSY_BIT] = config_busy;
        next_rdata[`LOCK_LOST_BIT] = lock_lost;
        next_rdata[`PLL_LOCKED_BIT] = pll_locked;
      end
      `EVENT_STATUS_ADDR: begin
        next_rdata[`EVENT_COUNT-1:0] = event_status;
      end
      `EVENT_MASK_ADDR: begin
        next_rdata[`EVENT_COUNT-1:0] = event_mask;
      end
      `LEAD_OFF_CONTROL_ADDR: begin
        next_rdata[`AC_ENABLE_BIT] = ac_lead_off_enable;
        next_rdata[`DC_ENABLE_BIT] = dc_lead_off_enable;
      end
      default: begin
        next_rdata = `STATUS_RESET;
      end
    endcase
  end

  // Read data stands for exactly the cycle after the read strobe, else zero,
  // which keeps a stale word from being mistaken for a fresh answer.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= `STATUS_RESET;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= `STATUS_RESET;
    end
  end

endmodule
`default_nettype wire

// >>> design/electrode_status_defines.vh
// Register offsets, field positions, reset values and timing counts for the status bank.
`ifndef ELECTRODE_STATUS_DEFINES_VH
`define ELECTRODE_STATUS_DEFINES_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define POWER_CONTROL_ADDR 8'h01
`define LEAD_OFF_STATUS_ADDR 8'h1d
`define DC_LEAD_OFF_FLAGS_ADDR 8'h1e
`define DEVICE_HEALTH_STATUS_ADDR 8'h30
`define EVENT_STATUS_ADDR 8'h31
`define EVENT_MASK_ADDR 8'h32
`define LEAD_OFF_CONTROL_ADDR 8'h33

// ****************************************************************
// Field positions
// ****************************************************************
`define POWER_ENABLE_BIT 1
`define OVERRANGE_MSB 23
`define OVERRANGE_LSB 20
`define OVERRANGE_COMMON_BIT 13
`define UNDERRANGE_MSB 12
`define UNDERRANGE_LSB 9
`define UNDERRANGE_COMMON_BIT 2
`define LEAD_STATUS_MSB 23
`define LEAD_STATUS_LSB 20
`define LEAD_STATUS_COMMON_BIT 13
`define INTERNAL_ERROR_BIT 3
`define CONFIG_BUSY_BIT 2
`define LOCK_LOST_BIT 1
`define PLL_LOCKED_BIT 0
`define AC_ENABLE_BIT 0
`define DC_ENABLE_BIT 1
`define EVENT_LOCK_LOST 0
`define EVENT_INTERNAL_ERROR 1
`define EVENT_DC_FLAG 2
`define EVENT_CONFIG_READY 3
`define EVENT_COUNT 4

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define STATUS_RESET 24'h000000
`define CONFIG_BUSY_RESET 1'b1
`define SYNC_STAGES 2

`endif

// >>> design/electrode_sync.v
// Two-stage synchroniser bank for comparator and lock inputs.
`default_nettype none

// Each bit passes two flops; only the second flop is visible outside.
module electrode_sync #(
  parameter WIDTH = 15
) (
  input wire mclk,
  input wire sys_rst,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  // ****************************************************************
  // Per-bit synchroniser
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg stage_a;
      reg stage_b;
      // The first stage feeds the second stage and nothing else.
      always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          stage_a <= 1'b0;
          stage_b <= 1'b0;
        end else begin
          stage_a <= async_in[i];
          stage_b <= stage_a;
        end
      end
      assign sync_out[i] = stage_b;
    end
  endgenerate

endmodule
`default_nettype wire

// >>> test/electrode_status_assertions.sv
// Concurrent checks on the status bank's register port and flags.
`default_nettype none

module electrode_status_assertions (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [23:0] reg_rdata,
  input wire logic [4:0] overrange_cmp,
  input wire logic [4:0] underrange_cmp,
  input wire logic pll_lock_raw,
  input wire logic core_fault,
  input wire logic power_enable,
  input wire logic ac_lead_off_enable,
  input wire logic dc_lead_off_enable,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] prev;
  logic [2:0] age;
  wire logic [10:0] now = {overrange_cmp, underrange_cmp, pll_lock_raw};

  // ********************
  // Input age counter
  // ********************
  // Checks wait until inputs have held long enough to clear the synchronisers.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prev <= 11'h000;
      age <= 3'h0;
    end else begin
      prev <= now;
      if (now != prev) age <= 3'h0;
      else if (age != 3'h7) age <= age + 3'h1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // ********************
  // Properties
  // ********************
  AST_RDATA_IDLE: assert property (!reg_read |=> reg_rdata == 24'h000000)
    else $error("read data not zero outside a read answer");
  AST_DC_RSVD: assert property (reg_read && reg_addr == 8'h1e |=>
    (reg_rdata & 24'h0fc1fb) == 24'h000000) else $error("dc flag reserved bit set");
  AST_HEALTH_RSVD: assert property (reg_read && reg_addr == 8'h30 |=>
    reg_rdata[23:4] == 20'h00000) else $error("health reserved bit set");
  AST_FLAGS: assert property (reg_read && reg_addr == 8'h1e && age >= 3'h4 |=>
    reg_rdata[23:20] == $past(overrange_cmp[3:0]) && reg_rdata[13] == $past(overrange_cmp[4])
    && reg_rdata[12:9] == $past(underrange_cmp[3:0]) && reg_rdata[2] == $past(underrange_cmp[4]))
    else $error("dc flags differ from comparators");
  AST_LOCK_MIRROR: assert property (reg_read && reg_addr == 8'h30 && age >= 3'h4 |=>
    reg_rdata[0] == $past(pll_lock_raw)) else $error("lock bit differs from lock input");
  AST_HEALTH_CLR: assert property ((reg_read && reg_addr == 8'h30 && age >= 3'h4
    && !core_fault) ##1 (reg_read && reg_addr == 8'h30 && !core_fault) |=> !reg_rdata[3]
    && !reg_rdata[1]) else $error("sticky health bits survive a read");
  AST_FAULT_SET: assert property (core_fault && !reg_read ##1 reg_read && reg_addr == 8'h30
    |=> reg_rdata[3]) else $error("internal error bit not set after fault");
  AST_LEAD_CTRL: assert property (reg_write && reg_addr == 8'h33 |=>
    {dc_lead_off_enable, ac_lead_off_enable} == $past(reg_wdata[1:0]))
    else $error("lead-off enables not written");

  cover property (reg_read && reg_addr == 8'h1e && age >= 3'h4);
  cover property ($rose(irq));
  cover property ($fell(power_enable));
endmodule

bind electrode_status_bank electrode_status_assertions electrode_status_assertions_i (
  .mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .overrange_cmp,
  .underrange_cmp, .pll_lock_raw, .core_fault, .power_enable, .ac_lead_off_enable,
  .dc_lead_off_enable, .irq
);

`default_nettype wire

// >>> test/host_model.sv
// Host side register master for the status bank.
`default_nettype none

module host_model (
  input wire logic mclk,
  input wire logic [23:0] reg_rdata,
  output var logic [7:0] reg_addr = 8'h00,
  output var logic [23:0] reg_wdata = 24'h000000,
  output var logic reg_write = 1'b0,
  output var logic reg_read = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;

  // One write, then a gap so the next call never reassigns in the same step.
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
    @(posedge mclk);
  endtask

  // One read, or two back to back when n is 2; answers are taken mid-cycle.
  task automatic rd(input logic [7:0] a, input int n, output logic [23:0] d0, d1);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    if (n == 1) reg_read <= 1'b0;
    @(negedge mclk) d0 = reg_rdata;
    @(posedge mclk);
    reg_read <= 1'b0;
    @(negedge mclk) d1 = reg_rdata;
    @(posedge mclk);
  endtask
endmodule

`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the electrode status register bank.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr;
  logic [23:0] reg_wdata, reg_rdata, d, x;
  logic reg_write, reg_read, power_enable, ac_lead_off_enable, dc_lead_off_enable, irq;
  logic pll_lock_raw = 1'b0, core_fault = 1'b0, config_loaded = 1'b0, frame_transfer = 1'b0;
  logic [4:0] over = 5'h00, under = 5'h00, ac = 5'h00;
  int fail_count = 0;
  int n_checks = 0;

  electrode_status_bank electrode_status_bank_i (
    .mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .overrange_cmp(over), .underrange_cmp(under), .ac_lead_off_cmp(ac), .pll_lock_raw,
    .core_fault, .config_loaded, .frame_transfer, .power_enable, .ac_lead_off_enable,
    .dc_lead_off_enable, .irq
  );
  host_model host_model_i (.mclk, .reg_rdata, .reg_addr, .reg_wdata, .reg_write, .reg_read);

  // ********************
  // Helpers
  // ********************
  initial forever #25 mclk = ~mclk;

  task automatic chk(input string n, input logic [23:0] e, g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic get(input logic [7:0] a, input logic [23:0] e);
    host_model_i.rd(a, 1, d, x);
    chk($sformatf("register %h", a), e, d);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Expected flag word built from the comparator levels.
  function automatic logic [23:0] dcw(input logic [4:0] o, u);
    dcw = 24'h000000;
    dcw[23:20] = o[3:0];
    dcw[13] = o[4];
    dcw[12:9] = u[3:0];
    dcw[2] = u[4];
  endfunction

  // ********************
  // Tests
  // ********************
  // A hang is cut short well past the under two hundred cycles the tests need.
  initial begin
    wt(3000);
    fail_count++;
    complete_run();
  end

  initial begin
    wt(6);
    sys_rst <= 1'b0;
    @(posedge mclk);
    get(8'h1e, 24'h000000);
    get(8'h30, 24'h000004);
    get(8'h7f, 24'h000000);
    config_loaded <= 1'b1;
    @(posedge mclk);
    config_loaded <= 1'b0;
    wt(3);
    chk("irq masked", 24'h0, {23'h0, irq});
    get(8'h30, 24'h000000);
    host_model_i.wr(8'h32, 24'h000008);
    wt(2);
    chk("irq raised", 24'h1, {23'h0, irq});
    get(8'h31, 24'h000008);
    wt(2);
    chk("irq cleared", 24'h0, {23'h0, irq});
    host_model_i.wr(8'h01, 24'h000002);
    host_model_i.wr(8'h33, 24'h000003);
    chk("enables", 24'h7, {21'h0, power_enable, dc_lead_off_enable, ac_lead_off_enable});
    // Walk one electrode at a time, then all at once.
    for (int i = 0; i < 6; i++) begin
      over <= (i < 5) ? 5'h01 << i : 5'h1f;
      under <= (i < 5) ? 5'h10 >> i : 5'h1f;
      wt(5);
      get(8'h1e, dcw(over, under));
    end
    // Both detectors on: limbs follow ac, the common electrode follows dc.
    over <= 5'h13;
    under <= 5'h00;
    ac <= 5'h0a;
    wt(5);
    frame_transfer <= 1'b1;
    @(posedge mclk);
    frame_transfer <= 1'b0;
    get(8'h1d, 24'ha02000);
    ac <= 5'h05;
    wt(5);
    get(8'h1d, 24'hf02000);
    frame_transfer <= 1'b1;
    @(posedge mclk);
    frame_transfer <= 1'b0;
    get(8'h1d, 24'h502000);
    host_model_i.wr(8'h33, 24'h000002);
    frame_transfer <= 1'b1;
    @(posedge mclk);
    frame_transfer <= 1'b0;
    get(8'h1d, 24'h302000);
    pll_lock_raw <= 1'b1;
    wt(5);
    get(8'h30, 24'h000001);
    pll_lock_raw <= 1'b0;
    wt(5);
    host_model_i.rd(8'h30, 2, d, x);
    chk("lock lost", 24'h000002, d);
    chk("lock lost read clear", 24'h000000, x);
    pll_lock_raw <= 1'b1;
    wt(5);
    pll_lock_raw <= 1'b0;
    wt(5);
    host_model_i.wr(8'h01, 24'h000000);
    chk("power off", 24'h0, {23'h0, power_enable});
    get(8'h30, 24'h000000);
    core_fault <= 1'b1;
    @(posedge mclk);
    core_fault <= 1'b0;
    host_model_i.rd(8'h30, 2, d, x);
    chk("fault", 24'h000008, d);
    chk("fault read clear", 24'h000000, x);
    // Lock-lost, internal error and new dc flag events are all pending now.
    get(8'h31, 24'h000007);
    // A second reset with comparators active: flags restart at zero, busy returns.
    sys_rst <= 1'b1;
    wt(2);
    sys_rst <= 1'b0;
    @(posedge mclk);
    get(8'h1e, 24'h000000);
    get(8'h30, 24'h000004);
    get(8'h1e, dcw(over, under));
    complete_run();
  end
endmodule

`default_nettype wire
